// ==== common/nsm_params.svh ====
// constants of the process-noise statistics monitor: offsets, fields, resets, timing
// assumes a 100 MHz clock and one pressure sample stream from the device's own sensor
//
// Overview of operation
// - mean from raw, spread from filtered or raw samples as the mode selects
// - statistics path leaves primary pressure untouched
// - input is always own pressure measurement
// - window length 1 to 1440 whole minutes
// - window length resets to 15 minutes
// - enable starts learning for one window
// - verify one window, compare with previous set
// - stable verify latches baselines, enters monitoring
// - unstable verify repeats until stable
// - skip setting takes learning set as baseline
// - skip-verification setting resets to no
// - compare only after full monitoring window
// - alert when mean or spread change exceeds limit
// - current mean and spread readable by host
// - monitoring entered without further host command
// - limits are percent change from baseline
// - zero limit disables detection, resets to zero
// - enable selects filtered or unfiltered spread
`ifndef NSM_PARAMS_SVH
`define NSM_PARAMS_SVH

// ****************************************
// timing
// ****************************************
`define NSM_CLK_PERIOD_NS 10
`define NSM_SEC_NS        1000000000
`define NSM_MINUTE_S      6'h3c

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define NSM_ADR_CTRL      12'h000
`define NSM_ADR_WINDOW    12'h004
`define NSM_ADR_MEAN_LIM  12'h008
`define NSM_ADR_HIGH_LIM  12'h00c
`define NSM_ADR_LOW_LIM   12'h010
`define NSM_ADR_STATUS    12'h014
`define NSM_ADR_CUR_MEAN  12'h018
`define NSM_ADR_CUR_SD    12'h01c
`define NSM_ADR_BASE_MEAN 12'h020
`define NSM_ADR_BASE_SD   12'h024

// ****************************************
// fields and reset values
// ****************************************
`define NSM_MODE_OFF      2'h0
`define NSM_MODE_HP       2'h1
`define NSM_MODE_RAW      2'h2
`define NSM_CTRL_SKIP     2
`define NSM_ST_MEAN       4
`define NSM_ST_HIGH       5
`define NSM_ST_LOW        6
`define NSM_ST_ANY        7
`define NSM_WIN_RESET     11'h00f
`define NSM_WIN_MIN       11'h001
`define NSM_WIN_MAX       11'h5a0
`define NSM_LIM_RESET     16'h0000
`define NSM_HP_SHIFT      4
`define NSM_FRAC          8
`define NSM_PCT           40'sh64
`define NSM_STABLE_PCT    40'sh0a

`endif

// ==== common/nsm_pkg.sv ====
// types of the process-noise statistics monitor
// assumes nothing beyond a SystemVerilog compiler
package nsm_pkg;

  typedef enum logic [1:0] {NSM_INACTIVE, NSM_LEARN, NSM_VERIFY, NSM_MONITOR} nsm_state_t;

  typedef struct packed {
    logic [31:0]        cnt;
    logic signed [47:0] sum;
    logic signed [47:0] dsum;
    logic [63:0]        dsq;
    logic               valid;
    logic signed [15:0] mean;
    logic [31:0]        var_w;
  } nsm_stat_t;

  typedef struct packed {
    logic        busy;
    logic [3:0]  idx;
    logic [31:0] x;
    logic [15:0] root;
    logic        done;
  } nsm_root_t;

  typedef struct packed {
    nsm_state_t         state;
    logic [1:0]         mode;
    logic               skip;
    logic [10:0]        win_len;
    logic [15:0]        mean_lim;
    logic [15:0]        high_lim;
    logic signed [15:0] low_lim;
    logic [31:0]        sec_cnt;
    logic [5:0]         min_sec;
    logic [10:0]        min_cnt;
    logic               close;
    logic signed [15:0] mean_hold;
    logic signed [15:0] cur_mean;
    logic [15:0]        cur_sd;
    logic signed [15:0] base_mean;
    logic [15:0]        base_sd;
    logic signed [15:0] prev_mean;
    logic [15:0]        prev_sd;
    logic               al_mean;
    logic               al_high;
    logic               al_low;
    logic               alert;
    logic signed [23:0] lp;
    logic [15:0]        pressure;
    logic               pressure_valid;
    logic               pready;
    logic               pslverr;
    logic [31:0]        prdata;
  } nsm_top_t;

endpackage

// ==== rtl/nsm_stat.sv ====
// window accumulator: mean of raw samples and variance of the spread input
// assumes i_close is a one-cycle pulse at the end of each window
`timescale 1ns/10ps
module nsm_stat (
  // clock and reset
  input  wire logic               i_clock,
  input  wire logic               i_rst,
  // control
  input  wire logic               i_clear,
  input  wire logic               i_close,
  // samples
  input  wire logic               i_valid,
  input  wire logic signed [15:0] i_raw,
  input  wire logic signed [15:0] i_dev,
  // results
  output logic                    o_valid,
  output logic signed [15:0]      o_mean,
  output logic [31:0]             o_var
);
  import nsm_pkg::*;

  nsm_stat_t          s_q;
  nsm_stat_t          s_d;
  logic signed [63:0] den;
  logic signed [63:0] mean64;
  logic signed [63:0] dmean;
  logic signed [63:0] var64;
  logic [31:0]        sq;

  always_comb begin
    s_d    = s_q;
    s_d.valid = 1'b0;
    den    = (s_q.cnt == 32'h0) ? 64'sh1 : $signed({32'h0, s_q.cnt});
    mean64 = 64'(s_q.sum) / den;
    dmean  = 64'(s_q.dsum) / den;
    var64  = $signed(s_q.dsq / $unsigned(den)) - dmean * dmean;
    // widen first: a 16-bit product would lose the top of large squares
    sq     = 32'(i_dev) * 32'(i_dev);
    if (i_close) begin
      s_d.valid = 1'b1;
      s_d.mean  = 16'(mean64);
      // rounding can dip the variance just below zero
      s_d.var_w = (var64 < 64'sh0) ? 32'h0 :
                  (var64 > 64'sh0ffffffff) ? 32'hffffffff : 32'(var64);
      s_d.cnt   = 32'h0;
      s_d.sum   = 48'sh0;
      s_d.dsum  = 48'sh0;
      s_d.dsq   = 64'h0;
    end
    if (i_valid) begin
      s_d.cnt  = s_d.cnt + 32'h1;
      s_d.sum  = s_d.sum + 48'(i_raw);
      s_d.dsum = s_d.dsum + 48'(i_dev);
      s_d.dsq  = s_d.dsq + {32'h0, sq};
    end
    if (i_clear) begin
      s_d = '0;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_valid = s_q.valid;
  assign o_mean  = s_q.mean;
  assign o_var   = s_q.var_w;
endmodule

// ==== rtl/nsm_root.sv ====
// sequential integer square root, one result bit per clock
// assumes i_go is not raised again while a result is pending
`timescale 1ns/10ps
module nsm_root (
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // request
  input  wire logic        i_go,
  input  wire logic [31:0] i_x,
  // answer
  output logic             o_done,
  output logic [15:0]      o_root
);
  import nsm_pkg::*;

  nsm_root_t   r_q;
  nsm_root_t   r_d;
  logic [15:0] trial;

  always_comb begin
    r_d      = r_q;
    r_d.done = 1'b0;
    trial    = r_q.root | (16'h1 << r_q.idx);
    if (r_q.busy) begin
      if ({16'h0, trial} * {16'h0, trial} <= r_q.x) begin
        r_d.root = trial;
      end
      if (r_q.idx == 4'h0) begin
        r_d.busy = 1'b0;
        r_d.done = 1'b1;
      end else begin
        r_d.idx = r_q.idx - 4'h1;
      end
    end
    if (i_go) begin
      r_d.busy = 1'b1;
      r_d.idx  = 4'hf;
      r_d.root = 16'h0;
      r_d.x    = i_x;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign o_done = r_q.done;
  assign o_root = r_q.root;
endmodule

// ==== rtl/nsm_top.sv ====
// process-noise statistics monitor: apb registers, window timing, learn/verify/monitor
// assumes pressure samples arrive synchronous to i_clock as one-cycle valid strobes
`timescale 1ns/10ps
`include "nsm_params.svh"
module nsm_top #(
  parameter int unsigned SEC_CYCLES = `NSM_SEC_NS / `NSM_CLK_PERIOD_NS
) (
  // clock and reset
  input  wire logic               i_clock,
  input  wire logic               i_rst,
  // apb slave
  input  wire logic               i_psel,
  input  wire logic               i_penable,
  input  wire logic               i_pwrite,
  input  wire logic [11:0]        i_paddr,
  input  wire logic [31:0]        i_pwdata,
  output logic [31:0]             o_prdata,
  output logic                    o_pready,
  output logic                    o_pslverr,
  // own pressure measurement
  input  wire logic               i_sample_valid,
  input  wire logic signed [15:0] i_sample,
  // primary path and monitor state
  output logic [15:0]             o_pressure,
  output logic                    o_pressure_valid,
  output nsm_pkg::nsm_state_t     o_state,
  output logic                    o_alert
);
  import nsm_pkg::*;

  // ****************************************
  // state and helpers
  // ****************************************
  nsm_top_t           s_q;
  nsm_top_t           s_d;
  logic signed [15:0] hp;
  logic signed [15:0] dev;
  logic signed [23:0] x_ext;
  logic               st_valid;
  logic signed [15:0] st_mean;
  logic [31:0]        st_var;
  logic               set_done;
  logic [15:0]        new_sd;
  logic               stable;
  logic               wr;
  logic               rd_hit;
  logic [31:0]        rd_data;
  logic [15:0]        low_mag;
  logic [31:0]        sec_last;

  function automatic logic over_pct(input logic signed [39:0] cur,
                                    input logic signed [39:0] base,
                                    input logic signed [39:0] lim);
    logic signed [39:0] d;
    logic signed [39:0] b;
    d = cur - base;
    if (d < 40'sh0) begin
      d = -d;
    end
    b = (base < 40'sh0) ? -base : base;
    over_pct = (d * `NSM_PCT) > (lim * b);
  endfunction

  // ****************************************
  // statistics datapath
  // ****************************************
  // first-order high pass: sample minus a slow running average
  assign x_ext = {i_sample, 8'h00};
  assign hp    = i_sample - 16'(s_q.lp >>> `NSM_FRAC);
  assign dev   = (s_q.mode == `NSM_MODE_RAW) ? i_sample : hp;

  // the monitor only ever listens to the device's own sample stream
  nsm_stat u_stat (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_clear (s_q.state == NSM_INACTIVE),
    .i_close (s_q.close),
    .i_valid (i_sample_valid),
    .i_raw   (i_sample),
    .i_dev   (dev),
    .o_valid (st_valid),
    .o_mean  (st_mean),
    .o_var   (st_var)
  );

  nsm_root u_root (
    .i_clock (i_clock),
    .i_rst   (i_rst),
    .i_go    (st_valid),
    .i_x     (st_var),
    .o_done  (set_done),
    .o_root  (new_sd)
  );

  assign stable = !over_pct(40'(s_q.mean_hold), 40'(s_q.prev_mean), `NSM_STABLE_PCT) &&
                  !over_pct(40'({1'b0, new_sd}), 40'({1'b0, s_q.prev_sd}), `NSM_STABLE_PCT);
  assign low_mag  = (s_q.low_lim < 16'sh0) ? 16'(-s_q.low_lim) : s_q.low_lim;
  assign sec_last = SEC_CYCLES - 32'h1;

  // ****************************************
  // register read decode
  // ****************************************
  always_comb begin
    rd_hit  = 1'b1;
    rd_data = 32'h0;
    case (i_paddr)
      `NSM_ADR_CTRL: begin
        rd_data = {29'h0, s_q.skip, s_q.mode};
      end
      `NSM_ADR_WINDOW: begin
        rd_data = {21'h0, s_q.win_len};
      end
      `NSM_ADR_MEAN_LIM: begin
        rd_data = {16'h0, s_q.mean_lim};
      end
      `NSM_ADR_HIGH_LIM: begin
        rd_data = {16'h0, s_q.high_lim};
      end
      `NSM_ADR_LOW_LIM: begin
        rd_data = {16'h0, s_q.low_lim};
      end
      `NSM_ADR_STATUS: begin
        rd_data = {24'h0, s_q.alert, s_q.al_low, s_q.al_high, s_q.al_mean, 2'h0, s_q.state};
      end
      `NSM_ADR_CUR_MEAN: begin
        rd_data = 32'(s_q.cur_mean);
      end
      `NSM_ADR_CUR_SD: begin
        rd_data = {16'h0, s_q.cur_sd};
      end
      `NSM_ADR_BASE_MEAN: begin
        rd_data = 32'(s_q.base_mean);
      end
      `NSM_ADR_BASE_SD: begin
        rd_data = {16'h0, s_q.base_sd};
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  assign wr = i_psel && i_penable && s_q.pready && i_pwrite;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_d       = s_q;
    s_d.close = 1'b0;

    // apb: ready is raised in the setup cycle so every access has one wait-free phase
    s_d.pready  = 1'b0;
    s_d.pslverr = 1'b0;
    if (i_psel && !i_penable && !s_q.pready) begin
      s_d.pready  = 1'b1;
      s_d.pslverr = !rd_hit;
      s_d.prdata  = (i_pwrite || !rd_hit) ? 32'h0 : rd_data;
    end
    if (wr) begin
      case (i_paddr)
        `NSM_ADR_CTRL: begin
          // mode three has no meaning, so the whole write is dropped
          if (i_pwdata[1:0] != 2'h3) begin
            s_d.mode = i_pwdata[1:0];
            s_d.skip = i_pwdata[`NSM_CTRL_SKIP];
          end
        end
        `NSM_ADR_WINDOW: begin
          if (i_pwdata >= 32'(`NSM_WIN_MIN) && i_pwdata <= 32'(`NSM_WIN_MAX)) begin
            s_d.win_len = i_pwdata[10:0];
          end
        end
        `NSM_ADR_MEAN_LIM: begin
          s_d.mean_lim = i_pwdata[15:0];
        end
        `NSM_ADR_HIGH_LIM: begin
          s_d.high_lim = i_pwdata[15:0];
        end
        `NSM_ADR_LOW_LIM: begin
          s_d.low_lim = i_pwdata[15:0];
        end
        default: begin
        end
      endcase
    end

    // primary path: a plain copy, nothing from the statistics feeds back into it
    s_d.pressure_valid = i_sample_valid;
    if (i_sample_valid) begin
      s_d.pressure = i_sample;
      s_d.lp       = s_q.lp + ((x_ext - s_q.lp) >>> `NSM_HP_SHIFT);
    end

    // window timebase: seconds, then minutes, then window close
    if (s_q.state != NSM_INACTIVE) begin
      s_d.sec_cnt = s_q.sec_cnt + 32'h1;
      if (s_q.sec_cnt >= sec_last) begin
        s_d.sec_cnt = 32'h0;
        s_d.min_sec = s_q.min_sec + 6'h1;
        if (s_q.min_sec + 6'h1 >= `NSM_MINUTE_S) begin
          s_d.min_sec = 6'h0;
          s_d.min_cnt = s_q.min_cnt + 11'h1;
          // >= so that shortening the window mid-run still closes it
          if (s_q.min_cnt + 11'h1 >= s_q.win_len) begin
            s_d.min_cnt = 11'h0;
            s_d.close   = 1'b1;
          end
        end
      end
    end

    // each finished window yields a fresh mean and spread set
    if (set_done) begin
      s_d.cur_mean = s_q.mean_hold;
      s_d.cur_sd   = new_sd;
    end
    if (st_valid) begin
      s_d.mean_hold = st_mean;
    end

    case (s_q.state)
      NSM_INACTIVE: begin
        if (s_q.mode != `NSM_MODE_OFF) begin
          s_d.state = NSM_LEARN;
        end
      end
      NSM_LEARN: begin
        if (set_done) begin
          s_d.prev_mean = s_q.mean_hold;
          s_d.prev_sd   = new_sd;
          if (s_q.skip) begin
            s_d.base_mean = s_q.mean_hold;
            s_d.base_sd   = new_sd;
            s_d.state     = NSM_MONITOR;
          end else begin
            s_d.state = NSM_VERIFY;
          end
        end
      end
      NSM_VERIFY: begin
        if (set_done) begin
          if (stable) begin
            s_d.base_mean = s_q.mean_hold;
            s_d.base_sd   = new_sd;
            s_d.state     = NSM_MONITOR;
          end else begin
            s_d.prev_mean = s_q.mean_hold;
            s_d.prev_sd   = new_sd;
          end
        end
      end
      NSM_MONITOR: begin
        // a set only appears after a whole monitoring window has passed
        if (set_done) begin
          s_d.al_mean = (s_q.mean_lim != `NSM_LIM_RESET) &&
                        over_pct(40'(s_q.mean_hold), 40'(s_q.base_mean), 40'({1'b0, s_q.mean_lim}));
          s_d.al_high = (s_q.high_lim != `NSM_LIM_RESET) && (new_sd > s_q.base_sd) &&
                        over_pct(40'({1'b0, new_sd}), 40'({1'b0, s_q.base_sd}),
                                 40'({1'b0, s_q.high_lim}));
          s_d.al_low  = (low_mag != `NSM_LIM_RESET) && (new_sd < s_q.base_sd) &&
                        over_pct(40'({1'b0, new_sd}), 40'({1'b0, s_q.base_sd}),
                                 40'({1'b0, low_mag}));
          s_d.alert   = s_d.al_mean || s_d.al_high || s_d.al_low;
        end
      end
      default: begin
        s_d.state = NSM_INACTIVE;
      end
    endcase

    // disable wins over everything: stop, forget, clear the alert
    if (s_q.mode == `NSM_MODE_OFF) begin
      s_d.state   = NSM_INACTIVE;
      s_d.sec_cnt = 32'h0;
      s_d.min_sec = 6'h0;
      s_d.min_cnt = 11'h0;
      s_d.al_mean = 1'b0;
      s_d.al_high = 1'b0;
      s_d.al_low  = 1'b0;
      s_d.alert   = 1'b0;
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      s_q          <= '0;
      s_q.win_len  <= `NSM_WIN_RESET;
      s_q.skip     <= 1'b0;
      s_q.mean_lim <= `NSM_LIM_RESET;
      s_q.high_lim <= `NSM_LIM_RESET;
      s_q.low_lim  <= `NSM_LIM_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_prdata         = s_q.prdata;
  assign o_pready         = s_q.pready;
  assign o_pslverr        = s_q.pslverr;
  assign o_pressure       = s_q.pressure;
  assign o_pressure_valid = s_q.pressure_valid;
  assign o_state          = s_q.state;
  assign o_alert          = s_q.alert;

  // ****************************************
  // checks
  // ****************************************
  a_primary_copy: assert property (@(posedge i_clock) disable iff (i_rst)
    i_sample_valid |=> (o_pressure == $past(i_sample)) && o_pressure_valid)
    else $error("primary pressure not copied");
  a_window_range: assert property (@(posedge i_clock) disable iff (i_rst)
    (s_q.win_len >= `NSM_WIN_MIN) && (s_q.win_len <= `NSM_WIN_MAX))
    else $error("window length out of range");
  a_disable_clears: assert property (@(posedge i_clock) disable iff (i_rst)
    (s_q.mode == `NSM_MODE_OFF) |=> (o_state == NSM_INACTIVE) && !o_alert)
    else $error("disable did not stop monitor");
  a_enable_learns: assert property (@(posedge i_clock) disable iff (i_rst)
    (o_state == NSM_INACTIVE) && (s_q.mode != `NSM_MODE_OFF) |=> o_state == NSM_LEARN)
    else $error("enable did not start learning");
  a_learn_skip: assert property (@(posedge i_clock) disable iff (i_rst)
    (o_state == NSM_LEARN) && set_done && s_q.skip && (s_q.mode != `NSM_MODE_OFF)
    |=> (o_state == NSM_MONITOR) && (s_q.base_mean == $past(s_q.mean_hold)))
    else $error("skip did not take learning baseline");
  a_learn_verify: assert property (@(posedge i_clock) disable iff (i_rst)
    (o_state == NSM_LEARN) && set_done && !s_q.skip && (s_q.mode != `NSM_MODE_OFF)
    |=> o_state == NSM_VERIFY)
    else $error("learning did not go to verify");
  a_verify_stay: assert property (@(posedge i_clock) disable iff (i_rst)
    (o_state == NSM_VERIFY) && set_done && !stable && (s_q.mode != `NSM_MODE_OFF)
    |=> o_state == NSM_VERIFY)
    else $error("unstable verify left verifying");
  a_verify_latch: assert property (@(posedge i_clock) disable iff (i_rst)
    (o_state == NSM_VERIFY) && set_done && stable && (s_q.mode != `NSM_MODE_OFF)
    |=> (o_state == NSM_MONITOR) && (s_q.base_sd == $past(new_sd)))
    else $error("stable verify did not latch baseline");
  a_zero_limit: assert property (@(posedge i_clock) disable iff (i_rst)
    (s_q.mean_lim == `NSM_LIM_RESET) && (o_state == NSM_MONITOR) && set_done |=> !s_q.al_mean)
    else $error("zero mean limit still alerted");
endmodule

// ==== tb/nsm_host.sv ====
// host side of the register bus: an apb master with one transfer task
// assumes one clock; the testbench calls xfer and judges the results
`timescale 1ns/10ps
module nsm_host (
  // clock
  input  wire logic        i_clock,
  // apb master
  output logic             o_psel,
  output logic             o_penable,
  output logic             o_pwrite,
  output logic [11:0]      o_paddr,
  output logic [31:0]      o_pwdata,
  input  wire logic [31:0] i_prdata,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr
);
  logic timed_out;
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 12'h000;
    o_pwdata = 32'h0;
    timed_out = 1'b0;
  end
  // window lengths outside 1..1440 are sent only when a refusal is wanted
  task automatic xfer(input logic wr, input logic [11:0] adr, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge i_clock);
    o_psel <= 1'b1;
    o_pwrite <= wr;
    o_paddr <= adr;
    o_pwdata <= wd;
    @(posedge i_clock);
    o_penable <= 1'b1;
    do begin
      @(posedge i_clock);
      n++;
    end while (i_pready !== 1'b1 && n < 50);
    rd = i_prdata;
    err = i_pslverr;
    if (n >= 50) timed_out = 1'b1;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    // released lines show a changed value so stale data is never mistaken for valid
    o_paddr <= ~adr;
    o_pwdata <= ~wd;
  endtask
endmodule

// ==== tb/test_process_noise_statistics_monitor.sv ====
// testbench of the noise statistics monitor: register, primary path and phase scenarios
// assumes nsm_top with SEC_CYCLES=4, so one minute is 240 clocks
`timescale 1ns/10ps
`include "nsm_params.svh"
module test_process_noise_statistics_monitor;
  import nsm_pkg::*;
  logic              i_clock, i_rst, psel, penable, pwrite, pready, pslverr;
  logic              smp_valid, pres_valid, alert;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata;
  logic signed [15:0] smp, base_lvl;
  logic [15:0]       pres;
  nsm_state_t        state;
  int                failures, checks_done;

  nsm_top #(.SEC_CYCLES(4)) uut (.i_clock(i_clock), .i_rst(i_rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_sample_valid(smp_valid), .i_sample(smp), .o_pressure(pres),
    .o_pressure_valid(pres_valid), .o_state(state), .o_alert(alert));
  nsm_host host (.i_clock(i_clock), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
    .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata), .i_pready(pready), .i_pslverr(pslverr));

  initial i_clock = 1'b0;
  always #5 i_clock = ~i_clock;
  // square-wave noise alternating between base_lvl and base_lvl+10, one sample per clock
  always @(posedge i_clock) begin
    smp_valid <= ~i_rst;
    smp <= (smp == base_lvl) ? base_lvl + 16'sd10 : base_lvl;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic stop_test();
    if (host.timed_out === 1'b1) failures++;
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [31:0] d;
    logic e;
    host.xfer(1'b1, a, v, d, e);
    chk("write err", {31'h0, e}, 32'h0);
    if (host.timed_out === 1'b1) stop_test();
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    logic e;
    host.xfer(1'b0, a, 32'h0, d, e);
    chk("read err", {31'h0, e}, 32'h0);
    if (host.timed_out === 1'b1) stop_test();
  endtask
  task automatic wait_state(input nsm_state_t st, input int lim);
    int n;
    n = 0;
    while (state !== st && n < lim) begin
      @(posedge i_clock);
      n++;
    end
    chk("state", {30'h0, state}, {30'h0, st});
    if (n >= lim) stop_test();
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_regs();
    logic [31:0] d;
    logic e;
    logic [31:0] wins[4];
    logic [31:0] exps[4];
    wins = '{32'h0, 32'h5a1, 32'h5a0, 32'h1};
    exps = '{32'hf, 32'hf, 32'h5a0, 32'h1};
    rd(`NSM_ADR_WINDOW, d);
    chk("window reset", d, 32'hf);
    rd(`NSM_ADR_CTRL, d);
    chk("ctrl reset", d, 32'h0);
    for (int a = 8; a <= 16; a += 4) begin
      rd(a[11:0], d);
      chk("limit reset", d, 32'h0);
    end
    for (int i = 0; i < 4; i++) begin
      wr(`NSM_ADR_WINDOW, wins[i]);
      rd(`NSM_ADR_WINDOW, d);
      chk("window value", d, exps[i]);
    end
    host.xfer(1'b0, 12'h028, 32'h0, d, e);
    chk("unmapped err", {31'h0, e}, 32'h1);
    wr(`NSM_ADR_CTRL, 32'h3);
    rd(`NSM_ADR_CTRL, d);
    chk("bad mode ignored", d, 32'h0);
  endtask
  task automatic t_primary();
    logic [15:0] last;
    repeat (2) begin
      @(posedge i_clock);
      #1 last = smp;
      @(posedge i_clock);
      #1 chk("primary copy", {15'h0, pres_valid, pres}, {15'h0, 1'b1, last});
    end
  endtask
  task automatic t_skip();
    logic [31:0] d;
    // let the high pass settle so the learned spread is that of the square wave alone
    repeat (100) @(posedge i_clock);
    wr(`NSM_ADR_CTRL, 32'h5);
    wait_state(NSM_LEARN, 3);
    repeat (200) @(posedge i_clock);
    chk("still learning", {30'h0, state}, {30'h0, NSM_LEARN});
    wait_state(NSM_MONITOR, 120);
    rd(`NSM_ADR_BASE_SD, d);
    chk("filtered spread", d, 32'h5);
    base_lvl <= 16'sd3000;
    repeat (300) @(posedge i_clock);
    chk("zero limits quiet", {31'h0, alert}, 32'h0);
    wr(`NSM_ADR_CTRL, 32'h0);
    wait_state(NSM_INACTIVE, 3);
  endtask
  task automatic t_full();
    logic [31:0] d;
    int n;
    base_lvl <= 16'sd1000;
    repeat (4) @(posedge i_clock);
    wr(`NSM_ADR_CTRL, 32'h2);
    wait_state(NSM_LEARN, 3);
    wait_state(NSM_VERIFY, 300);
    // a level step makes the next two verify sets disagree, so verifying must repeat
    base_lvl <= 16'sd2000;
    repeat (200) @(posedge i_clock);
    chk("still verifying", {30'h0, state}, {30'h0, NSM_VERIFY});
    repeat (140) @(posedge i_clock);
    chk("verify repeated", {30'h0, state}, {30'h0, NSM_VERIFY});
    wait_state(NSM_MONITOR, 400);
    rd(`NSM_ADR_BASE_MEAN, d);
    chk("baseline mean", {31'h0, d >= 32'd2004 && d <= 32'd2006}, 32'h1);
    rd(`NSM_ADR_BASE_SD, d);
    chk("raw spread", d, 32'h5);
    rd(`NSM_ADR_CUR_MEAN, d);
    chk("current mean", {31'h0, d >= 32'd2004 && d <= 32'd2006}, 32'h1);
    wr(`NSM_ADR_MEAN_LIM, 32'ha);
    wr(`NSM_ADR_HIGH_LIM, 32'ha);
    base_lvl <= 16'sd3000;
    repeat (190) @(posedge i_clock);
    chk("no early alert", {31'h0, alert}, 32'h0);
    n = 0;
    while (alert !== 1'b1 && n < 150) begin
      @(posedge i_clock);
      n++;
    end
    chk("mean alert", {31'h0, alert}, 32'h1);
    if (n >= 150) stop_test();
    rd(`NSM_ADR_STATUS, d);
    chk("status", d, 32'hb3);
    wr(`NSM_ADR_CTRL, 32'h0);
    wait_state(NSM_INACTIVE, 3);
    chk("alert cleared", {31'h0, alert}, 32'h0);
  endtask

  initial begin
    i_rst = 1'b1;
    smp_valid = 1'b0;
    smp = 16'sd0;
    base_lvl = 16'sd1000;
    failures = 0;
    checks_done = 0;
    repeat (2) @(posedge i_clock);
    i_rst <= 1'b0;
    t_regs();
    t_primary();
    t_skip();
    t_full();
    stop_test();
  end
endmodule
